// ---- dv/hit_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module hit_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the bench, one bit per filter 8..11
    input wire logic [3:0] fire,
    // Hits towards the block
    output var can_fbp_pkg::hit_t hits
);
    // Registered so each hit is a clean one-cycle pulse off the edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hits.hit <= 4'h0;
        end else begin
            hits.hit <= fire;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_can_filter_buffer_pointer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_can_filter_buffer_pointer;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    can_fbp_pkg::reg_req_t req = '0;
    logic [3:0] fire = 4'h0;
    can_fbp_pkg::hit_t hits;
    logic [15:0] rdata, ptr_value;
    logic route_valid, route_to_fifo;
    logic [3:0] route_buf;
    logic [1:0] route_filter;
    int failures = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    hit_source src_u (.clk(clk), .rst_b(rst_b), .fire(fire), .hits(hits));
    can_filter_buffer_pointer dut_u (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .hits(hits), .route_valid(route_valid), .route_to_fifo(route_to_fifo),
        .route_buf(route_buf), .route_filter(route_filter), .ptr_value(ptr_value));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk) req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Partner adds one cycle, the block one more
    task automatic hit(input logic [3:0] f, input logic [15:0] p, input int n);
        logic [3:0] v;
        v = p[n*4+:4];
        @(posedge clk) fire <= f;
        @(posedge clk) fire <= 4'h0;
        @(posedge clk) #1 chk({8'h00, route_valid, route_to_fifo, route_buf, route_filter},
            {8'h00, 1'b1, v == 4'hF, (v == 4'hF) ? 4'h0 : v, n[1:0]});
    endtask
    task automatic pattern(input logic [15:0] p);
        wr(4'h0, p);
        rd(4'h0, p);
        chk(ptr_value, p);
        for (int n = 0; n < 4; n++) hit(4'h1 << n, p, n);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk(ptr_value, 16'h0000);
        rd(4'h0, 16'h0000);
        hit(4'h1, 16'h0000, 0);
        pattern(16'hFE10);
        pattern(16'h01EF);
        wr(4'h3, 16'hFFFF);
        rd(4'h3, 16'h0000);
        rd(4'h0, 16'h01EF);
        hit(4'hF, 16'h01EF, 3);
        give_verdict;
    end
    initial begin
        #5000;
        failures++;
        give_verdict;
    end
endmodule
`default_nettype wire

// ---- hdl/can_filter_buffer_pointer.sv ----
`timescale 1ns/1ps
`default_nettype none
module can_filter_buffer_pointer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire can_fbp_pkg::reg_req_t req,
    output logic [15:0] rdata,
    // Filter hits for filters 8..11
    input wire can_fbp_pkg::hit_t hits,
    // Buffer write path
    output logic route_valid,
    output logic route_to_fifo,
    output logic [3:0] route_buf,
    output logic [1:0] route_filter,
    // Current pointer fields
    output logic [15:0] ptr_value
);

    can_fbp_pkg::state_t st_reg;
    can_fbp_pkg::state_t st_next;

    function automatic logic [3:0] field(input logic [15:0] p, input int lsb);
        field = p[lsb +: 4];
    endfunction

    // Only one word is mapped; every other address reads zero and ignores writes
    function automatic logic ptr_sel(input logic [3:0] a);
        ptr_sel = (a == can_fbp_pkg::PTR_OFFSET);
    endfunction

    // The all-ones code is the FIFO, every lower code a buffer number
    function automatic logic is_fifo(input logic [3:0] c);
        is_fifo = (c == can_fbp_pkg::DEST_FIFO);
    endfunction

    always_comb begin
        logic [3:0] code;
        code = 4'h0;
        st_next = st_reg;
        st_next.rdata = 16'h0000;
        st_next.route = '0;
        if (req.wr && ptr_sel(req.addr)) begin
            st_next.ptr = req.wdata;
        end
        if (req.rd && ptr_sel(req.addr)) begin
            st_next.rdata = st_reg.ptr;
        end
        // Highest filter number wins if several hit together; the matcher should give one
        if (hits.hit[3]) begin
            code = field(st_reg.ptr, can_fbp_pkg::ELEVEN_LSB);
            st_next.route.filter = 2'h3;
        end else if (hits.hit[2]) begin
            code = field(st_reg.ptr, can_fbp_pkg::TEN_LSB);
            st_next.route.filter = 2'h2;
        end else if (hits.hit[1]) begin
            code = field(st_reg.ptr, can_fbp_pkg::NINE_LSB);
            st_next.route.filter = 2'h1;
        end else if (hits.hit[0]) begin
            code = field(st_reg.ptr, can_fbp_pkg::EIGHT_LSB);
            st_next.route.filter = 2'h0;
        end
        // Pointer sampled before a same-cycle write takes effect
        st_next.route.valid = |hits.hit;
        st_next.route.to_fifo = (|hits.hit) && is_fifo(code);
        st_next.route.buf_idx = is_fifo(code) ? 4'h0 : code;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign route_valid = st_reg.route.valid;
    assign route_to_fifo = st_reg.route.to_fifo;
    assign route_buf = st_reg.route.buf_idx;
    assign route_filter = st_reg.route.filter;
    assign ptr_value = st_reg.ptr;

    AST_F11_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[3] |=> route_valid && route_filter == 2'h3 &&
        (route_to_fifo == ($past(ptr_value[15:12]) == 4'hF)))
        else $error("filter 11 routed wrongly");
    AST_F10_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h4 && ptr_value[11:8] != 4'hF |=>
        route_buf == $past(ptr_value[11:8]) && !route_to_fifo)
        else $error("filter 10 buffer index wrong");
    AST_F9_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h2 |=> route_filter == 2'h1 &&
        (route_to_fifo == ($past(ptr_value[7:4]) == 4'hF)))
        else $error("filter 9 routed wrongly");
    AST_F8_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h1 && ptr_value[3:0] != 4'hF |=>
        route_buf == $past(ptr_value[3:0]) && route_valid)
        else $error("filter 8 buffer index wrong");
    AST_NO_HIT: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h0 |=> !route_valid)
        else $error("route without hit");
    AST_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        req.wr && req.addr == 4'h0 |=> ptr_value == $past(req.wdata))
        else $error("pointer write lost");
    AST_READ: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && !req.wr && req.addr == 4'h0 |=> rdata == $past(ptr_value))
        else $error("pointer readback wrong");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !req.wr ##1 !req.wr |-> $stable(ptr_value))
        else $error("pointer changed without write");

    // Buffer index, FIFO choice and filter selection, by filter
    AST_F11_BUF: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[3] && ptr_value[15:12] != 4'hF |=>
        route_buf == $past(ptr_value[15:12]) && !route_to_fifo)
        else $error("filter 11 buffer index wrong");

    AST_F11_FIFO: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[3] && ptr_value[15:12] == 4'hF |=>
        route_to_fifo && route_buf == 4'h0)
        else $error("filter 11 fifo routing wrong");

    AST_F10_FIFO: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h4 && ptr_value[11:8] == 4'hF |=>
        route_to_fifo && route_buf == 4'h0 && route_filter == 2'h2)
        else $error("filter 10 fifo routing wrong");

    AST_F10_SEL: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[2] && !hits.hit[3] |=>
        route_valid && route_filter == 2'h2)
        else $error("filter 10 not selected");

    AST_F9_BUF: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h2 && ptr_value[7:4] != 4'hF |=>
        route_buf == $past(ptr_value[7:4]) && !route_to_fifo)
        else $error("filter 9 buffer index wrong");

    AST_F9_SEL: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[1] && hits.hit[3:2] == 2'h0 |=>
        route_valid && route_filter == 2'h1)
        else $error("filter 9 not selected");

    AST_F8_FIFO: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h1 && ptr_value[3:0] == 4'hF |=>
        route_to_fifo && route_buf == 4'h0)
        else $error("filter 8 fifo routing wrong");

    AST_F8_SEL: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h1 |=>
        route_valid && route_filter == 2'h0)
        else $error("filter 8 not selected");

    AST_F11_SEL: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit[3] |=>
        route_valid && route_filter == 2'h3)
        else $error("filter 11 not selected");

    // Shape of the routed pulse
    AST_VALID_ON_HIT: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit != 4'h0 |=>
        route_valid)
        else $error("hit not routed");

    AST_ROUTE_FROM_HIT: assert property (@(posedge clk) disable iff (!rst_b)
        route_valid |->
        $past(hits.hit) != 4'h0)
        else $error("route pulse without earlier hit");

    AST_IDLE_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
        !route_valid |->
        !route_to_fifo && route_buf == 4'h0 && route_filter == 2'h0)
        else $error("idle route fields not cleared");

    AST_FIFO_BUF_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        route_to_fifo |->
        route_buf == 4'h0 && route_valid)
        else $error("fifo route carries a buffer index");

    AST_OLD_PTR: assert property (@(posedge clk) disable iff (!rst_b)
        hits.hit == 4'h1 && req.wr && req.addr == 4'h0 |=>
        route_to_fifo == ($past(ptr_value[3:0]) == 4'hF))
        else $error("same-cycle write leaked into routing");

    // Register port corners
    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rd |=>
        rdata == 16'h0000)
        else $error("read data without read");

    AST_RDATA_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr != 4'h0 |=>
        rdata == 16'h0000)
        else $error("unmapped read not zero");

    AST_WRITE_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
        req.wr && req.addr != 4'h0 |=>
        $stable(ptr_value))
        else $error("unmapped write changed pointer");

endmodule
`default_nettype wire

// ---- shared/can_fbp_pkg.sv ----
package can_fbp_pkg;

    // Register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] PTR_OFFSET = 4'h0;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    // Pointer field positions (low bit of each 4-bit field)
    localparam int EIGHT_LSB = 0;
    localparam int NINE_LSB = 4;
    localparam int TEN_LSB = 8;
    localparam int ELEVEN_LSB = 12;

    localparam logic [3:0] DEST_FIFO = 4'hF;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] rdata;
    } reg_rsp_t;

    // Filter hit from the matching logic, one bit per filter 8..11
    typedef struct packed {
        logic [3:0] hit;
    } hit_t;

    // Routed write request towards the buffer write path
    typedef struct packed {
        logic valid;
        logic to_fifo;
        logic [3:0] buf_idx;
        logic [1:0] filter;
    } route_t;

    typedef struct packed {
        logic [15:0] ptr;
        logic [15:0] rdata;
        route_t route;
    } state_t;

endpackage
